// *** rtl/asc_control_port.v ***
// Software control port of a mono class-D amplifier: bus slave and settings
// Function
// RQ1: Shutdown pin low forces shutdown
// RQ2: Host enters sleep before shutdown
// RQ3: Audio format selectable LJ, RJ, I2S
// RQ4: Double-speed mode bit offered
// RQ5: Single-speed clock ratios per sample rate
// RQ6: Channel select bit picks left/right
// RQ7: Boost set before unmute, unchanged
// RQ8: Analog gain taken from register
// RQ9: Address LSB strapped once at power-up
// RQ10: Works at 100k and 400k bus
// RQ11: Slave only, never drives clock
// RQ12: Bytes MSB first, each acknowledged
// RQ13: Ack holds data low whole period
// RQ14: Master start/stop while clock high
// RQ15: First byte address plus direction
// RQ16: Any byte count between start, stop
// RQ17: Write: address, register, data bytes
// RQ18: Read: repeated start then data byte
// RQ19: Both gain pins high selects software
// RQ20: Pins become bus clock and data
// RQ21: Mismatched address leaves transfer ignored
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_control_port (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Device pins
  input wire amp_shutdown_n,
  input wire sleep_addr_strap,
  input wire [1:0] gain_select_pins,
  input wire hwmode_or_bus_clock_pin,
  input wire freqsel_or_bus_data_pin_in,
  output wire freqsel_or_bus_data_pin_out,
  output reg freqsel_or_bus_data_pin_oe,
  // Settings to the audio path
  output reg amp_shutdown,
  output reg amp_sleep,
  output reg software_mode,
  output reg [2:0] audio_format,
  output reg double_speed,
  output reg [1:0] digital_gain,
  output reg [1:0] analog_gain,
  output reg use_left_channel,
  output reg hw_mode_pin,
  output reg freq_select_pin
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_REG = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_RACK = 3'd5;

  // Two-flop synchronisers for all pins
  reg [5:0] sync1_ff;
  reg [5:0] sync2_ff;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 6'h3F;
      sync2_ff <= 6'h3F;
    end else begin
      sync1_ff <= {amp_shutdown_n, sleep_addr_strap, gain_select_pins,
                   hwmode_or_bus_clock_pin, freqsel_or_bus_data_pin_in};
      sync2_ff <= sync1_ff; // RQ10
    end
  end
  wire sd_n = sync2_ff[5];
  wire strap = sync2_ff[4];
  wire [1:0] gsel = sync2_ff[3:2];
  wire scl = sync2_ff[1];
  wire sda = sync2_ff[0];

  // Edge history on the synchronised bus lines
  reg scl_d_ff;
  reg sda_d_ff;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire sw = (gsel == `ASC_SWMODE_PINS); // RQ19
  wire start_c = sw & scl & scl_d_ff & sda_d_ff & ~sda; // RQ14
  wire stop_c = sw & scl & scl_d_ff & ~sda_d_ff & sda; // RQ14

  // Address strap caught once, after the synchroniser holds the real pin
  reg [1:0] strap_cnt_ff;
  reg addr_lsb_ff;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_ff <= 2'h0;
      addr_lsb_ff <= 1'b0;
    end else if (strap_cnt_ff != 2'h3) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `ASC_STRAP_EDGE) begin
        addr_lsb_ff <= strap; // RQ9
      end
    end
  end
  wire [6:0] my_addr = {`ASC_ADDR_UPPER, addr_lsb_ff};

  // Register storage
  reg [7:0] pwr_ff;
  reg [7:0] dig_ff;
  reg [7:0] volcfg_ff;
  reg [7:0] voll_ff;
  reg [7:0] volr_ff;
  reg [7:0] ana_ff;
  reg [7:0] fault_ff;
  reg [7:0] clip2_ff;
  reg [7:0] clip1_ff;

  // Bus slave state
  reg [2:0] state_ff;
  reg [3:0] bit_ff;
  reg [7:0] shift_ff;
  reg [7:0] ptr_ff;
  reg ack_ff;
  reg sda_low_ff;
  reg [7:0] rd_byte;

  // Read multiplexer
  always @* begin
    case (ptr_ff)
      `ASC_REG_PWR: rd_byte = pwr_ff;
      `ASC_REG_DIG: rd_byte = dig_ff;
      `ASC_REG_VOLCFG: rd_byte = volcfg_ff;
      `ASC_REG_VOLL: rd_byte = voll_ff;
      `ASC_REG_VOLR: rd_byte = volr_ff;
      `ASC_REG_ANA: rd_byte = ana_ff;
      `ASC_REG_FAULT: rd_byte = fault_ff;
      `ASC_REG_CLIP2: rd_byte = clip2_ff;
      `ASC_REG_CLIP1: rd_byte = clip1_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // Slave never drives clock; data line open-drain low only
  assign freqsel_or_bus_data_pin_out = 1'b0; // RQ11
  wire wr_now = (state_ff == ST_WDATA) & ack_ff & scl_fall & (bit_ff == 4'd8);

  // Bus slave sequencer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      bit_ff <= 4'd0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ack_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (!sw || stop_c) begin
      state_ff <= ST_IDLE; // RQ16
      sda_low_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (start_c) begin
      state_ff <= ST_ADDR; // RQ18
      bit_ff <= 4'd0;
      ack_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (state_ff != ST_IDLE) begin
      if (scl_rise && !ack_ff && bit_ff < 4'd8 && state_ff != ST_RDATA) begin
        shift_ff <= {shift_ff[6:0], sda}; // RQ12
        bit_ff <= bit_ff + 4'd1;
      end
      if (state_ff == ST_RDATA) begin
        if (scl_fall) begin
          if (bit_ff == 4'd8) begin
            state_ff <= ST_RACK;
            sda_low_ff <= 1'b0;
          end else begin
            sda_low_ff <= ~rd_byte[3'd7 - bit_ff[2:0]]; // RQ12
            bit_ff <= bit_ff + 4'd1;
          end
        end
      end else if (state_ff == ST_RACK) begin
        if (scl_rise) begin
          if (sda) begin
            state_ff <= ST_IDLE; // RQ18
          end else begin
            state_ff <= ST_RDATA;
            ptr_ff <= ptr_ff + 8'h01;
            bit_ff <= 4'd0;
          end
        end
      end else if (scl_fall && bit_ff == 4'd8) begin
        if (!ack_ff) begin
          if (state_ff == ST_ADDR && shift_ff[7:1] != my_addr) begin
            state_ff <= ST_IDLE; // RQ21
          end else begin
            ack_ff <= 1'b1;
            sda_low_ff <= 1'b1; // RQ13
          end
        end else begin
          ack_ff <= 1'b0;
          sda_low_ff <= 1'b0;
          bit_ff <= 4'd0;
          case (state_ff)
            ST_ADDR: begin
              if (shift_ff[0]) begin
                state_ff <= ST_RDATA; // RQ18
                sda_low_ff <= ~rd_byte[7];
                bit_ff <= 4'd1;
              end else begin
                state_ff <= ST_REG; // RQ17
              end
            end
            ST_REG: begin
              ptr_ff <= shift_ff; // RQ17
              state_ff <= ST_WDATA;
            end
            ST_WDATA: ptr_ff <= ptr_ff + 8'h01; // RQ16
            default: state_ff <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Register writes at the end of the data acknowledge
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_ff <= `ASC_RST_PWR;
      dig_ff <= `ASC_RST_DIG;
      volcfg_ff <= `ASC_RST_VOLCFG;
      voll_ff <= `ASC_RST_VOL;
      volr_ff <= `ASC_RST_VOL;
      ana_ff <= `ASC_RST_ANA;
      fault_ff <= 8'h00;
      clip2_ff <= `ASC_RST_CLIP2;
      clip1_ff <= `ASC_RST_CLIP1;
    end else if (wr_now) begin
      case (ptr_ff) // RQ17
        `ASC_REG_PWR: pwr_ff <= shift_ff;
        `ASC_REG_DIG: dig_ff <= shift_ff;
        `ASC_REG_VOLCFG: volcfg_ff <= shift_ff;
        `ASC_REG_VOLL: voll_ff <= shift_ff;
        `ASC_REG_VOLR: volr_ff <= shift_ff;
        `ASC_REG_ANA: ana_ff <= shift_ff;
        `ASC_REG_FAULT: fault_ff <= shift_ff;
        `ASC_REG_CLIP2: clip2_ff <= shift_ff;
        `ASC_REG_CLIP1: clip1_ff <= shift_ff;
        default: fault_ff <= fault_ff;
      endcase
    end
  end

  // Registered outputs to the audio path and the data pin enable
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      freqsel_or_bus_data_pin_oe <= 1'b0;
      amp_shutdown <= 1'b1;
      amp_sleep <= 1'b0;
      software_mode <= 1'b0;
      audio_format <= 3'd0;
      double_speed <= 1'b0;
      digital_gain <= 2'd0;
      analog_gain <= 2'd0;
      use_left_channel <= 1'b0;
      hw_mode_pin <= 1'b0;
      freq_select_pin <= 1'b0;
    end else begin
      freqsel_or_bus_data_pin_oe <= sda_low_ff & sw; // RQ13
      amp_shutdown <= ~sd_n; // RQ1
      amp_sleep <= sw ? pwr_ff[1] : strap;
      software_mode <= sw; // RQ19
      audio_format <= dig_ff[`ASC_DIG_FMT_LSB +: 3]; // RQ3
      double_speed <= sw & dig_ff[`ASC_DIG_SPEED]; // RQ4 RQ5
      digital_gain <= dig_ff[`ASC_DIG_BOOST_LSB +: 2];
      analog_gain <= sw ? ana_ff[`ASC_ANA_GAIN_LSB +: 2] : gsel; // RQ8
      use_left_channel <= ana_ff[`ASC_ANA_CHSEL]; // RQ6
      hw_mode_pin <= sw ? 1'b0 : scl; // RQ20
      freq_select_pin <= sw ? 1'b0 : sda; // RQ20
    end
  end
endmodule

// *** rtl/asc_map.vh ***
// Register map and protocol constants for the amplifier control port
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_ADDR_UPPER 6'h36
`define ASC_REG_ID 8'h00
`define ASC_REG_PWR 8'h01
`define ASC_REG_DIG 8'h02
`define ASC_REG_VOLCFG 8'h03
`define ASC_REG_VOLL 8'h04
`define ASC_REG_VOLR 8'h05
`define ASC_REG_ANA 8'h06
`define ASC_REG_FAULT 8'h08
`define ASC_REG_CLIP2 8'h10
`define ASC_REG_CLIP1 8'h11
`define ASC_RST_PWR 8'hFD
`define ASC_RST_DIG 8'h14
`define ASC_RST_VOLCFG 8'h80
`define ASC_RST_VOL 8'hCF
`define ASC_RST_ANA 8'h51
`define ASC_RST_CLIP2 8'hFF
`define ASC_RST_CLIP1 8'hFC
`define ASC_ANA_CHSEL 1
`define ASC_ANA_GAIN_LSB 2
`define ASC_DIG_FMT_LSB 0
`define ASC_DIG_SPEED 3
`define ASC_DIG_BOOST_LSB 4
`define ASC_SWMODE_PINS 2'b11
`define ASC_STRAP_EDGE 2'h2
`endif

// *** testbench/asc_port_monitor.sv ***
// Port assertions for the amplifier control port
`timescale 1ns/1ps
module asc_port_monitor (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Watched ports
  input wire amp_shutdown_n,
  input wire [1:0] gain_select_pins,
  input wire hwmode_or_bus_clock_pin,
  input wire freqsel_or_bus_data_pin_out,
  input wire freqsel_or_bus_data_pin_oe,
  input wire amp_shutdown,
  input wire software_mode,
  input wire double_speed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Gain pin levels held long enough to pass the synchronisers, and data line drive held once it rises
  sequence sw_pins;
    (gain_select_pins == 2'b11) [*6];
  endsequence
  sequence bit_held;
    freqsel_or_bus_data_pin_oe [*8];
  endsequence
  low_only_a: assert property (freqsel_or_bus_data_pin_out == 1'b0) else $error("sda high");
  shut_enter_a: assert property (!amp_shutdown_n [*6] |-> amp_shutdown) else $error("no sd");
  shut_leave_a: assert property (amp_shutdown_n [*6] |-> !amp_shutdown) else $error("sd");
  sw_enter_a: assert property (sw_pins |-> software_mode) else $error("no sw");
  sw_leave_a: assert property ((gain_select_pins != 2'b11) [*6] |-> !software_mode)
    else $error("sw");
  speed_hw_a: assert property (!software_mode [*2] |-> !double_speed) else $error("ds");
  bus_off_a: assert property (!software_mode [*2] |-> !freqsel_or_bus_data_pin_oe)
    else $error("bus");
  ack_hold_a: assert property ($rose(freqsel_or_bus_data_pin_oe) |-> bit_held)
    else $error("ack");
  scl_high_a: assert property (hwmode_or_bus_clock_pin [*3] |->
    $stable(freqsel_or_bus_data_pin_oe)) else $error("sda moved");
endmodule
bind asc_control_port asc_port_monitor MON (.clock(clock), .resetn(resetn),
  .amp_shutdown_n(amp_shutdown_n), .gain_select_pins(gain_select_pins),
  .hwmode_or_bus_clock_pin(hwmode_or_bus_clock_pin),
  .freqsel_or_bus_data_pin_out(freqsel_or_bus_data_pin_out),
  .freqsel_or_bus_data_pin_oe(freqsel_or_bus_data_pin_oe), .amp_shutdown(amp_shutdown),
  .software_mode(software_mode), .double_speed(double_speed));

// *** testbench/asc_bus_master.sv ***
// Bus master model on the control port clock and data lines
`timescale 1ns/1ps
module asc_bus_master (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire sda
);
  // Idle bus, clock owned by master only
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One clock; data moves while clock low
  task automatic clk_bit(input logic b, output logic r);
    sda_low = !b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask
  // Byte out MSB first, ninth clock for acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(nack, r);
  endtask
endmodule

// *** testbench/test_amp_sw_control_port.sv ***
// Self-checking bench for the amplifier control port
`timescale 1ns/1ps
module test_amp_sw_control_port;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sd_n = 1'b1;
  logic strap = 1'b1;
  logic [1:0] gp = 2'b11;
  logic [7:0] d;
  logic [7:0] dev = 8'hDA;
  wire scl, sda_low, sda, dout, oe, shut, sleep, swm, ds, left, hwp, fsp;
  wire [2:0] fmt;
  wire [1:0] dg, ag;
  int error_cnt = 0;
  int samples_checked = 0;
  // Wired-AND data line with pull-up
  assign sda = !((oe && !dout) || sda_low);
  asc_control_port DUT (.clock(clock), .resetn(resetn), .amp_shutdown_n(sd_n),
    .sleep_addr_strap(strap), .gain_select_pins(gp), .hwmode_or_bus_clock_pin(scl),
    .freqsel_or_bus_data_pin_in(sda), .freqsel_or_bus_data_pin_out(dout),
    .freqsel_or_bus_data_pin_oe(oe), .amp_shutdown(shut), .amp_sleep(sleep),
    .software_mode(swm), .audio_format(fmt), .double_speed(ds), .digital_gain(dg),
    .analog_gain(ag), .use_left_channel(left), .hw_mode_pin(hwp), .freq_select_pin(fsp));
  asc_bus_master PM (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial forever #5 clock = !clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic k;
    PM.start();
    PM.put(dev, k);
    check({7'h00, k}, 8'h01);
    PM.put(a, k);
    check({7'h00, k}, 8'h01);
    PM.put(v, k);
    check({7'h00, k}, 8'h01);
    PM.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic k;
    PM.start();
    PM.put(dev, k);
    check({7'h00, k}, 8'h01);
    PM.put(a, k);
    PM.start();
    PM.put(dev | 8'h01, k);
    check({7'h00, k}, 8'h01);
    PM.get(1'b1, v);
    PM.stop();
  endtask
  // Channel, gain and readback after a strap change
  task automatic t_channel();
    @(negedge clock) strap = 1'b0;
    rd(8'h06, d);
    check(d, 8'h51);
    wr(8'h06, 8'h5E);
    check({ag, 5'h00, left}, 8'hC1);
    rd(8'h06, d);
    check(d, 8'h5E);
    rd(8'h09, d);
    check(d, 8'h00);
  endtask
  // Every audio format in both speeds
  task automatic t_formats();
    for (int i = 0; i < 6; i++) begin
      wr(8'h02, 8'h20 | 8'(i / 3) << 3 | 8'(i % 3));
      check({2'h0, dg, ds, fmt}, 8'(8'h20 | (i / 3) << 3 | i % 3));
    end
  endtask
  // Foreign address gets no acknowledge and writes nothing
  task automatic t_foreign();
    logic k;
    PM.start();
    PM.put(8'hD8, k);
    check({7'h00, k}, 8'h00);
    PM.put(8'h06, k);
    PM.put(8'h00, k);
    PM.stop();
    rd(8'h06, d);
    check(d, 8'h5E);
  endtask
  // Sleep before shutdown, then hardware mode
  task automatic t_power();
    wr(8'h01, 8'hFF);
    check({7'h00, sleep}, 8'h01);
    @(negedge clock) sd_n = 1'b0;
    repeat (8) @(posedge clock);
    check({7'h00, shut}, 8'h01);
    @(negedge clock) sd_n = 1'b1;
    gp = 2'b01;
    repeat (8) @(posedge clock);
    check({5'h00, shut, ag}, 8'h01);
    check({5'h00, hwp, fsp, sleep}, 8'h06);
    @(negedge clock) gp = 2'b11;
    repeat (8) @(posedge clock);
    check({6'h00, hwp, fsp}, 8'h00);
  endtask
  // Fresh reset with the strap low moves the address to its even value
  task automatic t_strap();
    logic k;
    @(negedge clock) resetn = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    repeat (8) @(posedge clock);
    PM.start();
    PM.put(8'hDA, k);
    check({7'h00, k}, 8'h00);
    PM.stop();
    dev = 8'hD8;
    rd(8'h06, d);
    check(d, 8'h51);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500_000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    repeat (8) @(posedge clock);
    t_channel();
    t_formats();
    t_foreign();
    t_power();
    t_strap();
    close_out();
  end
endmodule
